// ### acem_consts.svh
// Constants for the audio clock error monitor: offsets, fields, resets, times.
// Assumes inclusion by bare name from the package and the monitor module.
`ifndef ACEM_CONSTS_SVH
`define ACEM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACEM_OFS_IGNORE_CTRL     8'h25
`define ACEM_OFS_DEBOUNCE_CTRL   8'h26
`define ACEM_OFS_MCLK_TOLERANCE  8'h27

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACEM_RST_IGNORE_CTRL     8'h00
`define ACEM_RST_DEBOUNCE_CTRL   8'h11
`define ACEM_RST_MCLK_TOLERANCE  8'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACEM_BIT_IGNORE_RATE     6
`define ACEM_BIT_IGNORE_BITCLK   5
`define ACEM_BIT_IGNORE_MCLK     4
`define ACEM_BIT_IGNORE_HALT     3
`define ACEM_BIT_IGNORE_MISSING  2
`define ACEM_BIT_DISABLE_AUTOSET 1
`define ACEM_BIT_IGNORE_PLL      0
`define ACEM_GOOD_HI             7
`define ACEM_GOOD_LO             4
`define ACEM_BAD_HI              3
`define ACEM_BAD_LO              0
`define ACEM_TOL_HI              4
`define ACEM_TOL_LO              0

// ----------------------------------------------------------------
// Bit-clock range and timing
// ----------------------------------------------------------------
`define ACEM_BCLK_MIN            32
`define ACEM_BCLK_MAX            256
`define ACEM_CLK_PERIOD_NS       8
`define ACEM_HALT_TIME_NS        1000
`define ACEM_HALT_CYCLES         (`ACEM_HALT_TIME_NS / `ACEM_CLK_PERIOD_NS)
`define ACEM_MISSING_UNIT_S      1
`define ACEM_MISSING_UNIT_CYCLES (`ACEM_MISSING_UNIT_S * 1000000000 / `ACEM_CLK_PERIOD_NS)

`endif

// ### acem_pkg.sv
// Types for the audio clock error monitor.
// Assumes acem_consts.svh is reachable on the include path.
package acem_pkg;

    `include "acem_consts.svh"

    // ----------------------------------------------------------------
    // Ignore and autoset controls
    // ----------------------------------------------------------------
    typedef struct packed {
        logic reserved;
        logic ignore_rate_detect;
        logic ignore_bitclk_detect;
        logic ignore_mclk_ratio_detect;
        logic ignore_clock_halt;
        logic ignore_clock_missing;
        logic disable_divider_autoset;
        logic ignore_pll_lock;
    } acem_ignore_type;

    // ----------------------------------------------------------------
    // Detector results
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rate_err;
        logic bitclk_err;
        logic mclk_err;
        logic halt_err;
        logic missing;
        logic pll_unlock;
    } acem_detect_type;

    typedef enum logic [1:0] {
        ACEM_BCLK_UNKNOWN,
        ACEM_BCLK_GOOD,
        ACEM_BCLK_BAD
    } acem_bclk_state_type;

endpackage : acem_pkg

// ### acem_monitor.sv
// Audio clock error monitor: bit clock, master clock, halt, missing, PLL lock.
// Assumes mclk_i at 125 MHz; audio clocks and PLL lock arrive asynchronously.
`timescale 1ns/1ns

`include "acem_consts.svh"

module acem_monitor
    import acem_pkg::*;
#(
    parameter int MISSING_UNIT_CYCLES = `ACEM_MISSING_UNIT_CYCLES,
    parameter int HALT_CYCLES         = `ACEM_HALT_CYCLES,
    parameter int MCLK_CNT_W          = 13
)(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // Register port
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Audio clock pins and PLL
    input  wire logic       bclk_i,
    input  wire logic       lrclk_i,
    input  wire logic       audio_mclk_i,
    input  wire logic       pll_locked_i,
    // Other detectors and settings
    input  wire logic       rate_error_i,
    input  wire logic [2:0] missing_detect_period_i,
    input  wire logic [6:0] auto_divider_i,
    input  wire logic [6:0] manual_divider_i,
    input  wire logic [2:0] auto_rate_mode_i,
    input  wire logic [2:0] manual_rate_mode_i,
    // Status outputs
    output logic            clock_error_o,
    output logic            powerdown_o,
    output logic            pll_lock_flag_o,
    output logic            bitclk_good_o,
    output logic            mclk_ratio_ok_o,
    output logic            clocks_missing_o,
    output logic      [6:0] divider_o,
    output logic      [2:0] rate_mode_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic ratio_match(input logic [MCLK_CNT_W-1:0] cnt,
                                         input logic [4:0]            tol);
        logic [MCLK_CNT_W-1:0] ratios [8];
        logic                  hit;
        ratios = '{13'h080, 13'h0C0, 13'h100, 13'h180,
                   13'h200, 13'h300, 13'h400, 13'h600};
        hit = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if ((cnt + MCLK_CNT_W'(tol) >= ratios[i]) &&
                (cnt <= ratios[i] + MCLK_CNT_W'(tol)))
                hit = 1'b1;
        end
        return hit;
    endfunction : ratio_match

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    acem_ignore_type       ign_ff,      nxt_ign;
    logic [7:0]            deb_ff,      nxt_deb;
    logic [4:0]            tol_ff,      nxt_tol;
    logic [7:0]            rdata_ff,    nxt_rdata;
    logic [2:0]            bclk_sh_ff,  nxt_bclk_sh;
    logic [2:0]            lrck_sh_ff,  nxt_lrck_sh;
    logic [2:0]            amck_sh_ff,  nxt_amck_sh;
    logic [1:0]            lock_sh_ff,  nxt_lock_sh;
    logic [8:0]            bcnt_ff,     nxt_bcnt;
    logic [8:0]            bprev_ff,    nxt_bprev;
    logic [3:0]            run_ff,      nxt_run;
    acem_bclk_state_type   bst_ff,      nxt_bst;
    logic [MCLK_CNT_W-1:0] mcnt_ff,     nxt_mcnt;
    logic                  mok_ff,      nxt_mok;
    logic                  bgood_ff,    nxt_bgood;
    logic [31:0]           halt_ff,     nxt_halt;
    logic [31:0]           low_ff,      nxt_low;
    logic [3:0]            lsec_ff,     nxt_lsec;
    acem_detect_type       det_ff,      nxt_det;
    logic                  err_ff,      nxt_err;
    logic                  pd_ff,       nxt_pd;
    logic [6:0]            div_ff,      nxt_div;
    logic [2:0]            rmode_ff,    nxt_rmode;

    logic                  bclk_rise;
    logic                  lrck_rise;
    logic                  amck_rise;
    logic                  frame_valid;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_ign     = ign_ff;
        nxt_deb     = deb_ff;
        nxt_tol     = tol_ff;
        nxt_bclk_sh = {bclk_sh_ff[1:0], bclk_i};
        nxt_lrck_sh = {lrck_sh_ff[1:0], lrclk_i};
        nxt_amck_sh = {amck_sh_ff[1:0], audio_mclk_i};
        nxt_lock_sh = {lock_sh_ff[0], pll_locked_i};
        bclk_rise   = bclk_sh_ff[1] & ~bclk_sh_ff[2];
        lrck_rise   = lrck_sh_ff[1] & ~lrck_sh_ff[2];
        amck_rise   = amck_sh_ff[1] & ~amck_sh_ff[2];
        nxt_bprev   = bprev_ff;
        nxt_run     = run_ff;
        nxt_bst     = bst_ff;
        nxt_mok     = mok_ff;
        nxt_lsec    = lsec_ff;

        // Register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `ACEM_OFS_IGNORE_CTRL:    nxt_ign = acem_ignore_type'({1'b0, reg_wdata_i[6:0]});
                `ACEM_OFS_DEBOUNCE_CTRL:  nxt_deb = reg_wdata_i;
                `ACEM_OFS_MCLK_TOLERANCE: nxt_tol = reg_wdata_i[`ACEM_TOL_HI:`ACEM_TOL_LO];
                default:                  nxt_ign = ign_ff;
            endcase
        end
        case (reg_addr_i)
            `ACEM_OFS_IGNORE_CTRL:    nxt_rdata = ign_ff;
            `ACEM_OFS_DEBOUNCE_CTRL:  nxt_rdata = deb_ff;
            `ACEM_OFS_MCLK_TOLERANCE: nxt_rdata = {3'h0, tol_ff};
            default:                  nxt_rdata = 8'h00;
        endcase

        // Bit clocks per frame, saturating
        frame_valid = (bcnt_ff >= 9'(`ACEM_BCLK_MIN)) && (bcnt_ff <= 9'(`ACEM_BCLK_MAX))
                      && (bcnt_ff == bprev_ff);
        nxt_bcnt = bcnt_ff + {8'h00, bclk_rise && bcnt_ff != 9'h1FF};
        nxt_mcnt = mcnt_ff + {{(MCLK_CNT_W-1){1'b0}}, amck_rise && mcnt_ff != {MCLK_CNT_W{1'b1}}};
        if (lrck_rise)
        begin
            nxt_bprev = bcnt_ff;
            nxt_bcnt  = 9'h000;
            nxt_mcnt  = MCLK_CNT_W'(0);
            nxt_mok   = ratio_match(mcnt_ff, tol_ff);
            nxt_run   = 4'h0;
            case (bst_ff)
                ACEM_BCLK_GOOD:
                begin
                    if (!frame_valid && run_ff == deb_ff[`ACEM_BAD_HI:`ACEM_BAD_LO])
                        nxt_bst = ACEM_BCLK_BAD;
                    else if (!frame_valid)
                        nxt_run = run_ff + 4'h1;
                end
                default:
                begin
                    if (frame_valid && run_ff == deb_ff[`ACEM_GOOD_HI:`ACEM_GOOD_LO])
                        nxt_bst = ACEM_BCLK_GOOD;
                    else if (frame_valid)
                        nxt_run = run_ff + 4'h1;
                    else
                        nxt_bst = ACEM_BCLK_BAD;
                end
            endcase
        end

        // Master clock halt timer
        nxt_halt = amck_rise ? 32'h0 : (halt_ff == 32'(HALT_CYCLES) ? halt_ff : halt_ff + 32'h1);

        // Both clocks held low; high is never missing
        nxt_low = low_ff + 32'h1;
        if (bclk_sh_ff[1] || lrck_sh_ff[1])
        begin
            nxt_low  = 32'h0;
            nxt_lsec = 4'h0;
        end
        else if (low_ff == 32'(MISSING_UNIT_CYCLES - 1))
        begin
            nxt_low  = 32'h0;
            nxt_lsec = lsec_ff + {3'h0, lsec_ff != 4'h8};
        end

        nxt_det.rate_err   = rate_error_i;
        nxt_det.bitclk_err = (bst_ff != ACEM_BCLK_GOOD);
        nxt_det.mclk_err   = ~mok_ff;
        nxt_det.halt_err   = (halt_ff == 32'(HALT_CYCLES));
        nxt_det.missing    = (lsec_ff > {1'b0, missing_detect_period_i});
        nxt_bgood          = (bst_ff == ACEM_BCLK_GOOD);
        nxt_det.pll_unlock = ~lock_sh_ff[1];

        nxt_err = (det_ff.rate_err   & ~ign_ff.ignore_rate_detect)
                | (det_ff.bitclk_err & ~ign_ff.ignore_bitclk_detect)
                | (det_ff.mclk_err   & ~ign_ff.ignore_mclk_ratio_detect)
                | (det_ff.halt_err   & ~ign_ff.ignore_clock_halt)
                | (det_ff.pll_unlock & ~ign_ff.ignore_pll_lock);
        nxt_pd  = det_ff.missing & ~ign_ff.ignore_clock_missing;

        // Divider source selection
        nxt_div   = ign_ff.disable_divider_autoset ? manual_divider_i : auto_divider_i;
        nxt_rmode = ign_ff.disable_divider_autoset ? manual_rate_mode_i
                                                   : auto_rate_mode_i;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ign_ff     <= acem_ignore_type'(`ACEM_RST_IGNORE_CTRL);
            deb_ff     <= `ACEM_RST_DEBOUNCE_CTRL;
            tol_ff     <= 5'(`ACEM_RST_MCLK_TOLERANCE);
            rdata_ff   <= 8'h00;
            bclk_sh_ff <= 3'h0;
            lrck_sh_ff <= 3'h0;
            amck_sh_ff <= 3'h0;
            lock_sh_ff <= 2'h0;
            bcnt_ff    <= 9'h000;
            bprev_ff   <= 9'h000;
            run_ff     <= 4'h0;
            bst_ff     <= ACEM_BCLK_UNKNOWN;
            mcnt_ff    <= '0;
            mok_ff     <= 1'b0;
            bgood_ff   <= 1'b0;
            halt_ff    <= 32'h0;
            low_ff     <= 32'h0;
            lsec_ff    <= 4'h0;
            det_ff     <= '0;
            err_ff     <= 1'b0;
            pd_ff      <= 1'b0;
            div_ff     <= 7'h00;
            rmode_ff   <= 3'h0;
        end
        else
        begin
            ign_ff     <= nxt_ign;
            deb_ff     <= nxt_deb;
            tol_ff     <= nxt_tol;
            rdata_ff   <= nxt_rdata;
            bclk_sh_ff <= nxt_bclk_sh;
            lrck_sh_ff <= nxt_lrck_sh;
            amck_sh_ff <= nxt_amck_sh;
            lock_sh_ff <= nxt_lock_sh;
            bcnt_ff    <= nxt_bcnt;
            bprev_ff   <= nxt_bprev;
            run_ff     <= nxt_run;
            bst_ff     <= nxt_bst;
            mcnt_ff    <= nxt_mcnt;
            mok_ff     <= nxt_mok;
            bgood_ff   <= nxt_bgood;
            halt_ff    <= nxt_halt;
            low_ff     <= nxt_low;
            lsec_ff    <= nxt_lsec;
            det_ff     <= nxt_det;
            err_ff     <= nxt_err;
            pd_ff      <= nxt_pd;
            div_ff     <= nxt_div;
            rmode_ff   <= nxt_rmode;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o      = rdata_ff;
    assign clock_error_o    = err_ff;
    assign powerdown_o      = pd_ff;
    assign pll_lock_flag_o  = lock_sh_ff[1];
    assign bitclk_good_o    = bgood_ff;
    assign mclk_ratio_ok_o  = mok_ff;
    assign clocks_missing_o = det_ff.missing;
    assign divider_o        = div_ff;
    assign rate_mode_o      = rmode_ff;

endmodule : acem_monitor

// ### acem_chk.sv
// Checker for the audio clock error monitor, bound to its ports.
// Assumes one clock domain; the ignore register is shadowed from writes.
`timescale 1ns/1ns
module acem_chk
    import acem_pkg::*;
#(
    parameter int HALT_CYCLES = 125
)(
    // Clock, reset and inputs
    input wire logic       mclk_i,
    input wire logic       reset_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       bclk_i,
    input wire logic       lrclk_i,
    input wire logic       audio_mclk_i,
    input wire logic       pll_locked_i,
    input wire logic       rate_error_i,
    input wire logic [6:0] auto_divider_i,
    input wire logic [6:0] manual_divider_i,
    // Outputs
    input wire logic       clock_error_o,
    input wire logic       powerdown_o,
    input wire logic       pll_lock_flag_o,
    input wire logic       clocks_missing_o,
    input wire logic [6:0] divider_o
);
    // ------------------------------
    // Shadow state
    // ------------------------------
    logic [7:0] ign_ff, nxt_ign;
    logic [3:0] age_ff, nxt_age;
    logic [8:0] still_ff, nxt_still;
    logic       mclk_d_ff;
    logic       calm;
    always_comb
    begin
        nxt_ign   = ign_ff;
        nxt_age   = age_ff + {3'h0, ~&age_ff};
        nxt_still = (audio_mclk_i != mclk_d_ff) ? 9'h000 : still_ff + {8'h00, ~&still_ff};
        if (reg_wr_i && reg_addr_i == 8'h25)
        begin
            nxt_ign = reg_wdata_i;
            nxt_age = 4'h0;
        end
    end
    always_ff @(posedge mclk_i)
    begin
        ign_ff    <= reset_i ? 8'h00 : nxt_ign;
        age_ff    <= reset_i ? 4'h0 : nxt_age;
        still_ff  <= reset_i ? 9'h000 : nxt_still;
        mclk_d_ff <= audio_mclk_i;
    end
    assign calm = age_ff > 4'h5;
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_pll_flag_true: assert property (
        $stable(pll_locked_i) [*6] |-> pll_lock_flag_o == pll_locked_i)
        else $error("pll flag differs from lock input");
    a_pll_err_raised: assert property (
        (!pll_locked_i) [*8] ##0 (calm && !ign_ff[0]) |-> clock_error_o)
        else $error("pll unlock without clock error");
    a_rate_err_raised: assert property (
        rate_error_i [*4] ##0 (calm && !ign_ff[6]) |-> clock_error_o)
        else $error("rate error without clock error");
    a_all_ignored_quiet: assert property (
        calm && (ign_ff & 8'h79) == 8'h79 |-> !clock_error_o)
        else $error("clock error with all detectors ignored");
    a_halt_err_raised: assert property (
        calm && !ign_ff[3] && int'(still_ff) > HALT_CYCLES + 10 |-> clock_error_o)
        else $error("halted master clock without clock error");
    a_powerdown_map: assert property (
        calm && $stable(clocks_missing_o) |-> powerdown_o == (clocks_missing_o && !ign_ff[2]))
        else $error("powerdown not missing and unignored");
    a_missing_low_only: assert property (
        $rose(clocks_missing_o) |-> !$past(bclk_i, 4) && !$past(lrclk_i, 4))
        else $error("missing raised while clocks high");
    a_divider_auto: assert property (
        calm && !ign_ff[1] && $stable(auto_divider_i) |-> divider_o == auto_divider_i)
        else $error("divider not automatic value");
    a_divider_manual: assert property (
        calm && ign_ff[1] && $stable(manual_divider_i) |-> divider_o == manual_divider_i)
        else $error("divider not manual value");
endmodule : acem_chk
bind acem_monitor acem_chk #(.HALT_CYCLES(HALT_CYCLES)) i_chk (.*);

// ### acem_audio_src.sv
// Audio source model: bit, frame and master clocks with steerable faults.
// Assumes the bench sets frame length, master half period and idle level.
`timescale 1ns/1ns
module acem_audio_src
    import acem_pkg::*;
(
    // Controls
    input  wire logic run_i,
    input  wire logic idle_high_i,
    input  wire logic mclk_run_i,
    input  int        nbclk_i,
    input  int        mclk_half_i,
    // Audio clocks
    output logic      bclk_o,
    output logic      lrclk_o,
    output logic      mclk_o = 1'b0
);
    // ------------------------------
    // Frames, still between runs
    // ------------------------------
    int n;
    always
    begin
        n = nbclk_i;
        if (!run_i)
        begin
            bclk_o  = idle_high_i;
            lrclk_o = idle_high_i;
            #64;
        end
        else
            for (int i = 0; i < n; i++)
            begin
                lrclk_o = (i < n / 2);
                bclk_o  = 1'b0;
                #64;
                bclk_o  = 1'b1;
                #64;
            end
    end
    always
    begin
        #(mclk_half_i);
        if (mclk_run_i)
            mclk_o = ~mclk_o;
    end
endmodule : acem_audio_src

// ### tb_top.sv
// Bench for the audio clock error monitor: registers, clock faults, masks.
// Assumes the monitor, the audio source model and the bound checker.
`timescale 1ns/1ns
`include "acem_consts.svh"
module tb_top
    import acem_pkg::*;
;
    // ------------------------------
    // Signals and instances
    // ------------------------------
    localparam int MISS_UNIT = 200;
    localparam int HALT      = `ACEM_HALT_CYCLES;
    localparam logic [6:0] AUTO_DIV = 7'h15, MAN_DIV = 7'h2A;
    localparam logic [2:0] AUTO_RATE = 3'h3, MAN_RATE = 3'h7;
    logic       mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, pll_locked = 1'b1;
    logic       rate_error = 1'b0, run = 1'b0, idle_high = 1'b0, mclk_run = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic [2:0] miss_period = 3'h0, rate_mode;
    logic [6:0] divider;
    logic       bclk, lrclk, amclk, clk_err, pdown, pll_flag, bgood, mok, missing;
    int         nbclk = 32, mclk_half = 16, error_cnt = 0, check_count = 0, cyc = 0;
    always #4 mclk = ~mclk;
    acem_audio_src i_src (.run_i(run), .idle_high_i(idle_high), .mclk_run_i(mclk_run),
        .nbclk_i(nbclk), .mclk_half_i(mclk_half), .bclk_o(bclk), .lrclk_o(lrclk),
        .mclk_o(amclk));
    acem_monitor #(.MISSING_UNIT_CYCLES(MISS_UNIT)) i_dut (.mclk_i(mclk), .reset_i(reset),
        .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata), .bclk_i(bclk), .lrclk_i(lrclk), .audio_mclk_i(amclk),
        .pll_locked_i(pll_locked), .rate_error_i(rate_error),
        .missing_detect_period_i(miss_period), .auto_divider_i(AUTO_DIV),
        .manual_divider_i(MAN_DIV), .auto_rate_mode_i(AUTO_RATE),
        .manual_rate_mode_i(MAN_RATE), .clock_error_o(clk_err), .powerdown_o(pdown),
        .pll_lock_flag_o(pll_flag), .bitclk_good_o(bgood), .mclk_ratio_ok_o(mok),
        .clocks_missing_o(missing), .divider_o(divider), .rate_mode_o(rate_mode));
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        step(2);
        chk(rdata, exp);
    endtask : rd
    task automatic rises(input int n);
        repeat (n) @(posedge lrclk);
        step(8);
    endtask : rises
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    // ------------------------------
    // Sequence
    // ------------------------------
    initial
    begin
        step(16);
        reset = 1'b0;
        step(1);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h11);
        rd(8'h27, 8'h04);
        rd(8'h30, 8'h00);
        wr(8'h25, 8'hFF);
        rd(8'h25, 8'h7F);
        wr(8'h27, 8'hFF);
        rd(8'h27, 8'h1F);
        wr(8'h25, 8'h00);
        wr(8'h27, 8'h04);
        chk(divider, AUTO_DIV);
        chk(rate_mode, AUTO_RATE);
        wr(8'h25, 8'h02);
        step(2);
        chk(divider, MAN_DIV);
        chk(rate_mode, MAN_RATE);
        wr(8'h25, 8'h00);
        wr(8'h26, 8'h31);
        run = 1'b1;
        rises(5);
        chk(bgood, 1'b0);
        rises(1);
        chk(bgood, 1'b1);
        chk(mok, 1'b1);
        chk(clk_err, 1'b0);
        nbclk = 256;
        rises(3);
        chk(bgood, 1'b1);
        nbclk = 257;
        rises(2);
        chk(bgood, 1'b1);
        rises(1);
        chk(bgood, 1'b0);
        chk(clk_err, 1'b1);
        wr(8'h25, 8'h20);
        step(6);
        chk(clk_err, 1'b0);
        wr(8'h25, 8'h00);
        nbclk = 32;
        rises(7);
        chk(bgood, 1'b1);
        mclk_half = 17;
        rises(3);
        chk(mok, 1'b0);
        chk(clk_err, 1'b1);
        wr(8'h27, 8'h1F);
        rises(2);
        chk(mok, 1'b1);
        wr(8'h27, 8'h04);
        wr(8'h25, 8'h10);
        rises(2);
        chk(mok, 1'b0);
        chk(clk_err, 1'b0);
        mclk_run = 1'b0;
        step(HALT + 20);
        chk(clk_err, 1'b1);
        wr(8'h25, 8'h18);
        step(6);
        chk(clk_err, 1'b0);
        wr(8'h25, 8'h79);
        step(6);
        mclk_run = 1'b1;
        mclk_half = 16;
        wr(8'h25, 8'h00);
        rises(2);
        chk(clk_err, 1'b0);
        pll_locked = 1'b0;
        step(8);
        chk(pll_flag, 1'b0);
        chk(clk_err, 1'b1);
        wr(8'h25, 8'h01);
        step(6);
        chk(clk_err, 1'b0);
        chk(pll_flag, 1'b0);
        pll_locked = 1'b1;
        wr(8'h25, 8'h00);
        rate_error = 1'b1;
        step(4);
        chk(clk_err, 1'b1);
        wr(8'h25, 8'h40);
        step(6);
        chk(clk_err, 1'b0);
        rate_error = 1'b0;
        wr(8'h25, 8'h00);
        run = 1'b0;
        idle_high = 1'b1;
        step(1000);
        chk(missing, 1'b0);
        miss_period = 3'h1;
        idle_high = 1'b0;
        step(MISS_UNIT * 3 / 2);
        chk(missing, 1'b0);
        step(MISS_UNIT);
        chk(missing, 1'b1);
        chk(pdown, 1'b1);
        wr(8'h25, 8'h04);
        step(4);
        chk(pdown, 1'b0);
        chk(missing, 1'b1);
        print_verdict();
    end
endmodule : tb_top
